//--- design/timer0_pkg.sv
// Purpose: shared constants and types of the 8-bit timer block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   all offsets are byte addresses
package timer0_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT  = 8'h00; // timer_count
  localparam logic [7:0] ADDR_INTCTL = 8'h04; // interrupt_control
  localparam logic [7:0] ADDR_OPTION = 8'h08; // option_config
  localparam logic [7:0] ADDR_STAT   = 8'h0C; // irq status, w1c
  localparam logic [7:0] ADDR_MASK   = 8'h10; // irq mask

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int IC_FLAG = 2;  // overflow_flag in interrupt_control
  localparam int IC_EN   = 5;  // overflow_irq_enable
  localparam int ST_OVF  = 0;  // overflow event in status and mask
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hFF;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] INHIBIT_CYC = 2'h2; // instr cycles held off
  localparam int         PHASES      = 4;    // pclk per instr cycle

  // instruction-cycle phases, gray order q1 q2 q3 q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_e;

  // option_config layout, bit 7 first
  typedef struct packed {
    logic       pullup_dis;          // stored only
    logic       int_edge;            // stored only
    logic       clock_source_select; // 1 external pin
    logic       source_edge_select;  // 1 falling edge
    logic       prescaler_assign;    // 1 watchdog
    logic [2:0] prescale_rate;
  } option_s;
endpackage : timer0_pkg

//--- design/pin_edge_sync.sv
// Purpose: bring the count pin into pclk and detect its edges
// Assumes: pin is asynchronous to pclk
// Notes:   edge is a one-cycle pulse
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic pin,      // asynchronous count pin
  input  wire logic fall_sel, // 1 counts high-to-low
  output logic      edge_hit  // selected edge seen
);
  // ----------------------------------------------------------------
  // two-flop synchroniser plus history flop
  // ----------------------------------------------------------------
  logic s1; // metastable stage, read only by s2
  logic s2; // synchronised level
  logic s3; // previous level

  // shift chain, frozen by clk_en
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (clk_en) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign edge_hit = fall_sel ? (s3 & ~s2) : (~s3 & s2);

  a_edge_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_hit && $past(clk_en) && $past(clk_en,2)) |->
    (s2 == !fall_sel && $past(s2) == fall_sel))
    else $error("edge pulse without selected transition");
endmodule : pin_edge_sync

//--- design/prescale_div.sv
// Purpose: shared binary prescaler with selectable tap
// Assumes: tick is a one-cycle pulse
// Notes:   shift n divides by 2**n, n of 0 passes tick through
`timescale 1ns/1ps
module prescale_div #(
  parameter int WIDTH = 8 // counter width, widest tap
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       clear,   // zero the count
  input  wire logic       tick,    // source pulse
  input  wire logic [3:0] shift,   // log2 of ratio
  output logic            tick_out // divided pulse
);
  // ----------------------------------------------------------------
  // counter and tap
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] cnt;  // not visible to software
  logic [WIDTH-1:0] mask; // low bits of the selected tap

  assign mask = ~({WIDTH{1'b1}} << shift);
  assign tick_out = tick & ((cnt & mask) == mask) & ~clear;

  // clear wins over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clk_en) begin
      if (clear) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  a_tap_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_out && clk_en) |=> ((cnt & mask) == '0 || $changed(shift)))
    else $error("prescaler tap did not wrap after output");
endmodule : prescale_div

//--- design/timer0_top.sv
// Purpose: 8-bit timer/counter with shared prescaler on APB
// Assumes: pclk is the oscillator, four pclk per instruction cycle
// Notes:   sleep and watchdog inputs come from pclk logic
//
// Function
// - timer mode steps once per instruction cycle
// - count write holds off two instruction cycles
// - bit 5 selects pin or instruction clock
// - bit 4 selects falling or rising pin edge
// - one prescaler, watchdog or timer, bit 3
// - rate code sets ratio, watchdog half
// - undivided timer only with watchdog assignment
// - count write clears timer-assigned prescaler
// - watchdog clear clears watchdog-assigned prescaler
// - wrap FFh to 00h sets overflow flag
// - flag sticks; request needs flag and enable
// - sleep freezes the counter
// - prescaler output sampled on phases two, four
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module timer0_top
  import timer0_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  input  wire logic        sleep,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        watchdog_src_tick,
  output logic             watchdog_tick,
  output logic             overflow_irq_req,
  output logic             irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] timer_count;   // the counter
  option_s    opt;           // option_config
  logic       overflow_flag; // sticky overflow flag
  logic       ovf_irq_en;    // overflow_irq_enable
  logic       stat;          // irq status, overflow event
  logic       mask;          // irq mask
  phase_e     phase;         // instruction-cycle phase
  logic [1:0] inhibit;       // instr cycles left to hold off
  logic       pend;          // divided tick awaiting sample

  // ----------------------------------------------------------------
  // internal nets
  // ----------------------------------------------------------------
  logic       run;        // counting allowed
  logic       q2;         // second_phase_clock
  logic       q4;         // fourth_phase_clock
  logic       sample;     // q2 or q4
  logic       ext_edge;   // selected pin edge
  logic       src_tick;   // chosen source pulse
  logic       pre_in;     // prescaler input
  logic [3:0] pre_shift;  // prescaler tap
  logic       pre_clear;  // prescaler clear
  logic       pre_en;     // prescaler enable
  logic       pre_out;    // prescaler output
  logic       tim_tick;   // pulse offered to the counter
  logic       inc;        // counter steps this cycle
  logic       ovf;        // counter wraps this cycle
  logic       hit;        // address is mapped
  logic [7:0] rd_data;    // read mux
  logic       bus_done;   // last access cycle
  logic       wr;         // accepted write
  logic       count_wr;   // write to timer_count
  logic       intctl_wr;  // write to interrupt_control
  logic       option_wr;  // write to option_config
  logic       stat_wr;    // write to status
  logic       mask_wr;    // write to mask

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // access completes on the second penable cycle
  assign bus_done  = clk_en & psel & penable & pready;
  assign wr        = bus_done & pwrite & hit;
  assign count_wr  = wr & (paddr == ADDR_COUNT);
  assign intctl_wr = wr & (paddr == ADDR_INTCTL);
  assign option_wr = wr & (paddr == ADDR_OPTION);
  assign stat_wr   = wr & (paddr == ADDR_STAT);
  assign mask_wr   = wr & (paddr == ADDR_MASK);

  // read mux; unused bits read zero
  always_comb begin
    rd_data = 8'h00;
    hit     = 1'b1;
    case (paddr)
      ADDR_COUNT:  rd_data = timer_count;
      ADDR_INTCTL: begin
        rd_data[IC_FLAG] = overflow_flag;
        rd_data[IC_EN]   = ovf_irq_en;
      end
      ADDR_OPTION: rd_data = opt;
      ADDR_STAT:   rd_data[ST_OVF] = stat;
      ADDR_MASK:   rd_data[ST_OVF] = mask;
      default:     hit = 1'b0;
    endcase
  end

  // one wait state; data and error ready with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        prdata  <= {24'h00_0000, rd_data};
        pslverr <= ~hit;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction-cycle phases
  // ----------------------------------------------------------------
  // sleep stops the timer
  assign run    = clk_en & ~sleep;
  assign q2     = (phase == PH_Q2);
  assign q4     = (phase == PH_Q4);
  assign sample = q2 | q4;

  // gray walk q1 q2 q3 q4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_Q1;
    end else if (run) begin
      case (phase)
        PH_Q1:   phase <= PH_Q2;
        PH_Q2:   phase <= PH_Q3;
        PH_Q3:   phase <= PH_Q4;
        PH_Q4:   phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source and prescaler routing
  // ----------------------------------------------------------------
  pin_edge_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .pin      (external_count_pin),
    .fall_sel (opt.source_edge_select),
    .edge_hit (ext_edge)
  );

  // pin edges or one per instruction cycle
  assign src_tick = opt.clock_source_select ? ext_edge : q4;
  assign pre_in = opt.prescaler_assign ? watchdog_src_tick : src_tick;
  // timer ratio is one tap deeper than watchdog
  assign pre_shift = opt.prescaler_assign ? {1'b0, opt.prescale_rate}
                   : {1'b0, opt.prescale_rate} + 4'h1;
  assign pre_clear = opt.prescaler_assign
                   ? (clk_en & watchdog_clear_instruction) : count_wr;
  // watchdog keeps its prescaler through sleep
  assign pre_en = clk_en & (opt.prescaler_assign | ~sleep | pre_clear);

  prescale_div #(.WIDTH(8)) u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (pre_en),
    .clear    (pre_clear),
    .tick     (pre_in),
    .shift    (pre_shift),
    .tick_out (pre_out)
  );

  // undivided only when watchdog holds it
  assign tim_tick = opt.prescaler_assign ? src_tick : pre_out;

  // divided or undivided tick to the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_tick <= 1'b0;
    end else if (clk_en) begin
      watchdog_tick <= opt.prescaler_assign ? pre_out
                     : watchdog_src_tick;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // pin ticks wait for the next q2 or q4 sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
    end else if (count_wr) begin
      pend <= 1'b0;
    end else if (run) begin
      if (sample) begin
        pend <= 1'b0;
      end else if (tim_tick) begin
        pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit <= 2'h0;
    end else if (count_wr) begin
      inhibit <= INHIBIT_CYC;
    end else if (run && q4 && inhibit != 2'h0) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  assign inc = run & sample & (pend | tim_tick)
             & (inhibit == 2'h0) & ~count_wr;
  assign ovf = inc & (timer_count == COUNT_MAX);

  // a software write beats a step in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= COUNT_RST;
    end else if (count_wr) begin
      timer_count <= pwdata[7:0];
    end else if (inc) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // option_config; upper two bits only stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt <= OPTION_RST;
    end else if (option_wr) begin
      opt <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // flags and interrupts
  // ----------------------------------------------------------------
  // wrap sets the flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      ovf_irq_en    <= 1'b0;
    end else begin
      if (ovf) begin
        overflow_flag <= 1'b1;
      end else if (intctl_wr) begin
        overflow_flag <= pwdata[IC_FLAG];
      end
      if (intctl_wr) begin
        ovf_irq_en <= pwdata[IC_EN];
      end
    end
  end

  // status write-one-to-clear; mask plain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= 1'b0;
      mask <= 1'b0;
    end else begin
      if (ovf) begin
        stat <= 1'b1;
      end else if (stat_wr && pwdata[ST_OVF]) begin
        stat <= 1'b0;
      end
      if (mask_wr) begin
        mask <= pwdata[ST_OVF];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_req <= 1'b0;
      irq              <= 1'b0;
    end else if (clk_en) begin
      overflow_irq_req <= overflow_flag & ovf_irq_en;
      irq              <= stat & mask;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wrap;
    inc && timer_count == COUNT_MAX;
  endsequence

  sequence s_write;
    count_wr;
  endsequence

  a_timer_step: assert property ((run && q4 && inhibit == 2'h0
    && !count_wr && opt.prescaler_assign
    && !opt.clock_source_select) |=>
    timer_count == $past(timer_count) + 8'h01)
    else $error("timer mode missed an instruction cycle");

  a_write_hold: assert property (s_write |=>
    ($stable(timer_count) || $past(count_wr))[*5])
    else $error("counter moved during write hold-off");

  a_int_phase: assert property ((inc && !opt.clock_source_select)
    |-> q4)
    else $error("internal source stepped off q4");

  a_sample_pts: assert property (inc |-> (q2 || q4))
    else $error("counter stepped outside q2 or q4");

  a_undivided: assert property ((opt.prescaler_assign && run
    && !opt.clock_source_select && q4) |-> tim_tick)
    else $error("watchdog-assigned timer not undivided");

  a_route_one: assert property ((!opt.prescaler_assign
    && watchdog_src_tick && !src_tick) |-> !tim_tick)
    else $error("watchdog source reached the timer");

  a_pre_clear: assert property ((count_wr && !opt.prescaler_assign)
    |=> u_pre.cnt == 8'h00)
    else $error("count write left prescaler running");

  a_wdt_clear: assert property ((clk_en && opt.prescaler_assign
    && watchdog_clear_instruction) |=> u_pre.cnt == 8'h00)
    else $error("watchdog clear left prescaler running");

  a_wrap_flag: assert property (s_wrap |=>
    (overflow_flag && stat && timer_count == 8'h00))
    else $error("wrap did not set overflow flag");

  a_req_gate: assert property (overflow_irq_req |->
    $past(overflow_flag && ovf_irq_en))
    else $error("request without flag and enable");

  a_flag_hold: assert property ((overflow_flag && !intctl_wr)
    |=> overflow_flag)
    else $error("overflow flag dropped by hardware");

  a_sleep_frz: assert property ((sleep && !count_wr)
    |=> $stable(timer_count))
    else $error("counter moved during sleep");
endmodule : timer0_top

//--- verif/count_source.sv
// Purpose: pulse source that drives the external count pin
// Assumes: pulses are far slower than the phase sampling
// Notes:   the pin is always driven and rests low between bursts
`timescale 1ns/1ps
module count_source (
  input  wire logic pclk, // oscillator clock
  output logic      pin   // external count pin
);
  // -------------------------------------------------------------
  // pulse shaping
  // -------------------------------------------------------------
  localparam int HALF = 8; // pclk per half pulse, two instr cycles

  initial pin = 1'b0;

  // pulse timing: one level change, then a long settle so
  // that synchroniser and phase sampling have surely seen it
  task automatic level(input logic v);
    @(posedge pclk);
    pin <= v;
    repeat (24) @(posedge pclk);
  endtask : level

  // pulse timing: whole pulses, rising edge first
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge pclk);
      pin <= 1'b1;
      repeat (HALF) @(posedge pclk);
      pin <= 1'b0;
      repeat (HALF - 1) @(posedge pclk);
    end
    repeat (24) @(posedge pclk);
  endtask : burst
endmodule : count_source

//--- verif/timer0_top_tb_top.sv
// Purpose: self-checking bench of the 8-bit timer block
// Assumes: slave answers each APB access within a bounded wait
// Notes:   counts are checked as deltas between evenly paced reads
`timescale 1ns/1ps
module timer0_top_tb_top import timer0_pkg::*; ;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic        pclk, presetn;        // clock and reset
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;   // rv: last read data
  logic        pready, pslverr, ev;  // ev: last error flag
  logic        sleep, wclr, wsrc, ce; // sleep, watchdog, clock enable
  logic        pin, wtick, ireq, irq;
  logic [7:0]  a;                    // count taken before a gap
  int          n_errors, cmp_count, wd_n, s;

  timer0_top timer0_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .external_count_pin(pin), .sleep(sleep),
    .watchdog_clear_instruction(wclr),
    .watchdog_src_tick(wsrc), .watchdog_tick(wtick),
    .overflow_irq_req(ireq), .irq(irq));

  count_source count_source_i (.pclk(pclk), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // watchdog output pulses, counted for ratio checks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_n <= 0;
    else if (wtick === 1'b1) wd_n <= wd_n + 1;
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic wsend(input int n);
    repeat (n) begin
      @(posedge pclk);
      wsrc <= 1'b1;
      @(posedge pclk);
      wsrc <= 1'b0;
    end
    cyc(4);
  endtask : wsend

  task automatic wclear();
    @(posedge pclk);
    wclr <= 1'b1;
    @(posedge pclk);
    wclr <= 1'b0;
  endtask : wclear

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // hang guard, far beyond the planned run of some 7k cycles
  initial begin
    cyc(40000);
    n_errors++;
    summarize();
  end

  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, sleep, wclr, wsrc} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cyc(6);
    presetn <= 1'b1;
    // reset values, then an unmapped place
    apb(0, ADDR_COUNT, 0);
    chk("count_rst", rv, {24'h0, COUNT_RST});
    apb(0, ADDR_OPTION, 0);
    chk("option_rst", rv, {24'h0, OPTION_RST});
    apb(0, ADDR_INTCTL, 0);
    chk("intctl_rst", rv, 32'h0);
    apb(0, 8'h14, 0);
    chk("unmapped_rd", {ev, rv[30:0]}, 32'h80000000);
    apb(1, 8'h14, 32'hFF);
    chk("unmapped_wr", ev, 1);
    // watchdog ratios: each rate code from an aligned start
    for (int r = 0; r < 8; r++) begin
      apb(1, ADDR_OPTION, 32'h08 | r);
      wclear();
      s = wd_n;
      wsend(2 << r);
      chk("wdt_ratio", wd_n - s, 2);
    end
    apb(1, ADDR_OPTION, 32'h0B);
    apb(0, ADDR_OPTION, 0);
    chk("option_rw", rv, 32'h0B);
    wclear();
    wsend(5);
    wclear();
    s = wd_n;
    wsend(7);
    chk("wdt_clear", wd_n - s, 0);
    wsend(1);
    chk("wdt_clear_end", wd_n - s, 1);
    // undivided stepping with prescaler on the watchdog
    apb(1, ADDR_OPTION, 32'h08);
    apb(0, ADDR_COUNT, 0);
    a = rv[7:0];
    cyc(36);
    apb(0, ADDR_COUNT, 0);
    chk("step_1to1", 8'(rv[7:0] - a), 10);
    // clock enable low freezes phases: only 8 enabled cycles pass
    a = rv[7:0];
    @(posedge pclk) ce <= 1'b0;
    cyc(40);
    @(posedge pclk) ce <= 1'b1;
    cyc(3);
    apb(0, ADDR_COUNT, 0);
    chk("ce_freeze", 8'(rv[7:0] - a), 2);
    // write holds counting off for two instr cycles
    apb(1, ADDR_COUNT, 32'h40);
    cyc(36);
    apb(0, ADDR_COUNT, 0);
    chk("inhibit", 32'(rv[7:0] >= 8'h47 && rv[7:0] <= 8'h48), 1);
    // overflow with flag, enable, status and mask
    apb(1, ADDR_MASK, 1);
    apb(1, ADDR_INTCTL, 32'h20);
    apb(1, ADDR_COUNT, 32'hFE);
    cyc(40);
    chk("irq_set", irq, 1);
    chk("req_set", ireq, 1);
    apb(0, ADDR_INTCTL, 0);
    chk("flag_set", rv, 32'h24);
    apb(0, ADDR_STAT, 0);
    chk("stat_set", rv, 32'h1);
    apb(1, ADDR_STAT, 1);
    cyc(2);
    chk("irq_clr", irq, 0);
    chk("req_sticky", ireq, 1);
    apb(1, ADDR_INTCTL, 32'h20);
    cyc(2);
    chk("req_clr", ireq, 0);
    apb(1, ADDR_MASK, 0);
    apb(1, ADDR_INTCTL, 0);
    apb(1, ADDR_COUNT, 32'hFE);
    cyc(40);
    chk("irq_masked", irq, 0);
    chk("req_disabled", ireq, 0);
    apb(0, ADDR_INTCTL, 0);
    chk("flag_no_en", rv, 32'h04);
    apb(0, ADDR_STAT, 0);
    chk("stat_masked", rv, 32'h1);
    apb(1, ADDR_STAT, 1);
    apb(1, ADDR_INTCTL, 0);
    // sleep freezes the counter, so no wrap occurs
    @(posedge pclk) sleep <= 1'b1;
    apb(1, ADDR_COUNT, 32'hFF);
    cyc(60);
    apb(0, ADDR_COUNT, 0);
    chk("sleep_hold", rv, 32'hFF);
    apb(0, ADDR_INTCTL, 0);
    chk("sleep_noflag", rv, 32'h0);
    @(posedge pclk) sleep <= 1'b0;
    // move to timer: clear, then assignment and rate at once
    wclear();
    apb(1, ADDR_OPTION, 32'h00);
    s = wd_n;
    wsend(3);
    chk("wdt_bypass", wd_n - s, 3);
    // timer ratios over two steps each
    for (int r = 0; r < 8; r++) begin
      apb(1, ADDR_OPTION, r);
      apb(0, ADDR_COUNT, 0);
      a = rv[7:0];
      cyc(8 * (2 << r) - 4);
      apb(0, ADDR_COUNT, 0);
      chk("tmr_ratio", 8'(rv[7:0] - a), 2);
    end
    // count write empties the timer prescaler (1:256)
    apb(1, ADDR_COUNT, 0);
    cyc(896);
    apb(0, ADDR_COUNT, 0);
    chk("psc_cleared", rv, 32'h0);
    cyc(300);
    apb(0, ADDR_COUNT, 0);
    chk("psc_first", rv, 32'h1);
    // move to watchdog in the prescribed order
    wclear();
    apb(1, ADDR_COUNT, 0);
    apb(1, ADDR_OPTION, 32'h08);
    wclear();
    // pin pulses and single edges in counter mode
    apb(1, ADDR_OPTION, 32'h28);
    apb(0, ADDR_COUNT, 0);
    a = rv[7:0];
    count_source_i.burst(5);
    apb(0, ADDR_COUNT, 0);
    chk("pin_count", 8'(rv[7:0] - a), 5);
    for (int f = 0; f < 2; f++) begin
      apb(1, ADDR_OPTION, 32'h28 | (f << 4));
      apb(0, ADDR_COUNT, 0);
      a = rv[7:0];
      count_source_i.level(1'b1);
      apb(0, ADDR_COUNT, 0);
      chk("edge_rise", 8'(rv[7:0] - a), 1 - f);
      a = rv[7:0];
      count_source_i.level(1'b0);
      apb(0, ADDR_COUNT, 0);
      chk("edge_fall", 8'(rv[7:0] - a), f);
    end
    // pin through the 1:2 prescaler, sampled on phases
    wclear();
    apb(1, ADDR_OPTION, 32'h20);
    apb(0, ADDR_COUNT, 0);
    a = rv[7:0];
    count_source_i.burst(8);
    apb(0, ADDR_COUNT, 0);
    chk("pin_div2", 8'(rv[7:0] - a), 4);
    summarize();
  end
endmodule : timer0_top_tb_top
